// File: inc/epid_pkg.sv
// Package of constants and types for the external pin interrupt detector.
`default_nettype none
package epid_pkg;
   localparam logic [1:0] EPID_REG_STATUS_CONTROL = 2'h0;
   localparam logic [1:0] EPID_REG_PIN_STATUS     = 2'h1;
   localparam int EPID_BIT_EDGE_LEVEL_MODE    = 0;
   localparam int EPID_BIT_REQUEST_ENABLE     = 1;
   localparam int EPID_BIT_EVENT_ACKNOWLEDGE  = 2;
   localparam int EPID_BIT_EVENT_FLAG         = 3;
   localparam int EPID_BIT_PIN_FUNCTION_EN    = 4;
   localparam int EPID_BIT_POLARITY_SELECT    = 5;
   localparam logic [7:0] EPID_CTRL_RESET     = 8'h00;
   localparam logic [7:0] EPID_CTRL_WR_MASK   = 8'h33;
   localparam int EPID_SYNC_STAGES            = 2;
   typedef enum logic [2:0] {
      EPID_BUS_IDLE  = 3'b001,
      EPID_BUS_ACK   = 3'b010,
      EPID_BUS_SPACE = 3'b100
   } epid_bus_state_t;
endpackage : epid_pkg
`default_nettype wire

// File: inc/epid_if.sv
// Interface carrying register controls and detector status between modules.
`timescale 1ns/10ps
`default_nettype none
interface epid_if;
   logic polarity_select;
   logic pin_function_enable;
   logic edge_level_mode;
   logic ack_pulse;
   logic event_flag;
   logic pin_level;
   logic pin_asserted;
   modport regs (output polarity_select, output pin_function_enable,
                 output edge_level_mode, output ack_pulse,
                 input event_flag, input pin_level, input pin_asserted);
   modport det  (input polarity_select, input pin_function_enable,
                 input edge_level_mode, input ack_pulse,
                 output event_flag, output pin_level, output pin_asserted);
endinterface : epid_if
`default_nettype wire

// File: src/epid_sync.sv
// Two-stage synchroniser for the external request pin.
`timescale 1ns/10ps
`default_nettype none
module epid_sync
   import epid_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic d_in,
   output var  logic q_out
);
   logic [EPID_SYNC_STAGES-1:0] stage_reg;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage_reg <= '0;
      end else begin
         stage_reg <= {stage_reg[EPID_SYNC_STAGES-2:0], d_in};
      end
   end

   assign q_out = stage_reg[EPID_SYNC_STAGES-1];
endmodule // epid_sync
`default_nettype wire

// File: src/epid_detect.sv
// Edge and level event detector holding the event flag.
`timescale 1ns/10ps
`default_nettype none
module epid_detect
   import epid_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic pin_in,
   epid_if.det       ctl
);
   logic pin_sync;
   logic prev_reg;
   logic flag_reg;
   logic asserted;
   logic edge_seen;
   logic event_now;

   // The pin arrives through the top's synchroniser, so it is safe to use.
   assign pin_sync = pin_in;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= pin_sync; // see RULE_11
      end
   end

   // Polarity picks which level counts as asserted.
   assign asserted  = ctl.polarity_select ? pin_sync : ~pin_sync; // see RULE_02
   assign edge_seen = ctl.polarity_select ? (pin_sync & ~prev_reg)
                                          : (~pin_sync & prev_reg); // see RULE_11
   assign event_now = ctl.pin_function_enable &
                      (edge_seen | (ctl.edge_level_mode & asserted)); // see RULE_10

   // A new event wins over an acknowledge in the same cycle.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flag_reg <= 1'b0;
      end else if (event_now) begin
         flag_reg <= 1'b1; // see RULE_06
      end else if (ctl.ack_pulse) begin
         flag_reg <= 1'b0; // see RULE_07, see RULE_08
      end
   end

   assign ctl.event_flag   = flag_reg;
   assign ctl.pin_level    = pin_sync;
   assign ctl.pin_asserted = asserted;
endmodule // epid_detect
`default_nettype wire

// File: src/epid_top.sv
// Top of the external pin interrupt detector with its Wishbone slave.
// Notes on behaviour
// RULE_01 - Eight-bit status/control register; bits 7 and 6 always read zero.
// RULE_02 - Polarity bit 5: zero means falling/low, one means rising/high.
// RULE_03 - Enabled pin with rising polarity switches pull-up to pull-down.
// RULE_04 - Pin enable bit 4 turns the pin request function on or off.
// RULE_05 - While enabled, an internal pull resistor is switched on.
// RULE_06 - Flag bit 3 is set by detected events; writes cannot change it.
// RULE_07 - Acknowledge bit 2: writing one clears the flag, reads give zero.
// RULE_08 - In edge-and-level mode, acknowledge cannot clear while pin asserted.
// RULE_09 - Request enable bit 1 drives the interrupt request from the flag.
// RULE_10 - Mode bit 0: zero edges only, one edges and sustained level.
// RULE_11 - Pin is synchronised, edges from samples, events only while enabled.
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module epid_top
   import epid_pkg::*;
(
   input  wire logic        SYS_CLK_IN,
   input  wire logic        ARST_N_IN,
   input  wire logic        WB_CYC_IN,
   input  wire logic        WB_STB_IN,
   input  wire logic        WB_WE_IN,
   input  wire logic [3:0]  WB_SEL_IN,
   input  wire logic [3:0]  WB_ADR_IN,
   input  wire logic [31:0] WB_DAT_IN,
   output var  logic [31:0] WB_DAT_OUT,
   output var  logic        WB_ACK_OUT,
   input  wire logic        EXT_PIN_IN,
   output var  logic        PULL_ENABLE_OUT,
   output var  logic        PULL_DOWN_SELECT_OUT,
   output var  logic        IRQ_REQUEST_OUT
);
   logic [1:0]      rst_sync_reg;
   logic            rst_n;
   logic            polarity_reg;
   logic            pin_en_reg;
   logic            req_en_reg;
   logic            mode_reg;
   logic            ack_reg;
   logic [31:0]     dat_reg;
   logic [31:0]     dat_next;
   epid_bus_state_t bus_state_reg;
   logic            req;
   logic            wr_ctrl;
   logic            lane0;
   logic            pull_en_reg;
   logic            pull_dn_reg;
   logic            irq_reg;
   logic            pin_sync;

   epid_if ctl ();

   // Reset is released through two stages to avoid a ragged release.
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // Pin synchroniser; only its second stage reaches the detector.
   epid_sync u_pin_sync (
      .clk_in   (SYS_CLK_IN),
      .rst_n_in (rst_n),
      .d_in     (EXT_PIN_IN),
      .q_out    (pin_sync) // see RULE_11
   );

   epid_detect u_detect (
      .clk_in   (SYS_CLK_IN),
      .rst_n_in (rst_n),
      .pin_in   (pin_sync),
      .ctl      (ctl.det)
   );

   // Word address decode, register index from address bits 3:2.
   function automatic logic is_reg(input logic [3:0] adr,
                                   input logic [1:0] idx);
      is_reg = (adr[3:2] == idx) && (adr[1:0] == 2'h0);
   endfunction

   assign req     = WB_CYC_IN & WB_STB_IN & (bus_state_reg == EPID_BUS_IDLE);
   assign lane0   = WB_SEL_IN[0];
   assign wr_ctrl = req & WB_WE_IN & lane0 &
                    is_reg(WB_ADR_IN, EPID_REG_STATUS_CONTROL);

   // Slave answers one cycle after the request, then rests a cycle.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         bus_state_reg <= EPID_BUS_IDLE;
      end else begin
         case (bus_state_reg)
            EPID_BUS_IDLE: begin
               if (WB_CYC_IN && WB_STB_IN) begin
                  bus_state_reg <= EPID_BUS_ACK;
               end
            end
            EPID_BUS_ACK: begin
               bus_state_reg <= EPID_BUS_SPACE;
            end
            default: begin
               bus_state_reg <= EPID_BUS_IDLE;
            end
         endcase
      end
   end
   assign WB_ACK_OUT = (bus_state_reg == EPID_BUS_ACK);

   // Control fields; only the writable bits are stored, one flop each.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         polarity_reg <= EPID_CTRL_RESET[EPID_BIT_POLARITY_SELECT];
      end else if (wr_ctrl) begin
         polarity_reg <= WB_DAT_IN[EPID_BIT_POLARITY_SELECT]; // see RULE_02
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         pin_en_reg <= EPID_CTRL_RESET[EPID_BIT_PIN_FUNCTION_EN];
      end else if (wr_ctrl) begin
         pin_en_reg <= WB_DAT_IN[EPID_BIT_PIN_FUNCTION_EN]; // see RULE_04
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         req_en_reg <= EPID_CTRL_RESET[EPID_BIT_REQUEST_ENABLE];
      end else if (wr_ctrl) begin
         req_en_reg <= WB_DAT_IN[EPID_BIT_REQUEST_ENABLE]; // see RULE_09
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= EPID_CTRL_RESET[EPID_BIT_EDGE_LEVEL_MODE];
      end else if (wr_ctrl) begin
         mode_reg <= WB_DAT_IN[EPID_BIT_EDGE_LEVEL_MODE]; // see RULE_10
      end
   end

   // Acknowledge pulse; blocked while the level is still asserted in
   // level mode, because the flag would simply be set again.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= wr_ctrl & WB_DAT_IN[EPID_BIT_EVENT_ACKNOWLEDGE] &
                    ~(mode_reg & pin_en_reg & ctl.pin_asserted); // see RULE_07, see RULE_08
      end
   end

   assign ctl.polarity_select     = polarity_reg;
   assign ctl.pin_function_enable = pin_en_reg;
   assign ctl.edge_level_mode     = mode_reg;
   assign ctl.ack_pulse           = ack_reg;

   // Read data; upper bits and acknowledge read as zero.
   always_comb begin
      dat_next = 32'h0000_0000;
      if (is_reg(WB_ADR_IN, EPID_REG_STATUS_CONTROL)) begin
         dat_next[EPID_BIT_POLARITY_SELECT] = polarity_reg; // see RULE_01
         dat_next[EPID_BIT_PIN_FUNCTION_EN] = pin_en_reg;
         dat_next[EPID_BIT_EVENT_FLAG]      = ctl.event_flag; // see RULE_06
         dat_next[EPID_BIT_REQUEST_ENABLE]  = req_en_reg;
         dat_next[EPID_BIT_EDGE_LEVEL_MODE] = mode_reg;
      end else if (is_reg(WB_ADR_IN, EPID_REG_PIN_STATUS)) begin
         dat_next[0] = ctl.pin_level;
         dat_next[1] = ctl.pin_asserted;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         dat_reg <= 32'h0000_0000;
      end else if (req && !WB_WE_IN) begin
         dat_reg <= dat_next;
      end
   end
   assign WB_DAT_OUT = dat_reg;

   // Pin pull resistor control; registered so the pad sees no glitches.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         pull_en_reg <= 1'b0;
      end else begin
         pull_en_reg <= pin_en_reg; // see RULE_05
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         pull_dn_reg <= 1'b0;
      end else begin
         pull_dn_reg <= pin_en_reg & polarity_reg; // see RULE_03
      end
   end

   // Interrupt request follows the flag one cycle later while request enable is set.
   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= req_en_reg & ctl.event_flag; // see RULE_09
      end
   end
   assign PULL_ENABLE_OUT      = pull_en_reg;
   assign PULL_DOWN_SELECT_OUT = pull_dn_reg;
   assign IRQ_REQUEST_OUT      = irq_reg;
endmodule // epid_top
`default_nettype wire

// File: tb/epid_checker.sv
// Concurrent checks on the ports of the pin interrupt detector top.
`timescale 1ns/10ps
`default_nettype none
module epid_checker (
   input wire logic        SYS_CLK_IN,
   input wire logic        ARST_N_IN,
   input wire logic        WB_CYC_IN,
   input wire logic        WB_STB_IN,
   input wire logic        WB_WE_IN,
   input wire logic [3:0]  WB_ADR_IN,
   input wire logic [31:0] WB_DAT_OUT,
   input wire logic        WB_ACK_OUT,
   input wire logic        PULL_ENABLE_OUT,
   input wire logic        PULL_DOWN_SELECT_OUT,
   input wire logic        IRQ_REQUEST_OUT
);
   wire req_w = WB_CYC_IN & WB_STB_IN;
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack stood longer than one cycle");
   ack_latency_a: assert property ($rose(req_w) |=> WB_ACK_OUT)
      else $error("ack did not follow the request by one cycle");
   ack_needs_req_a: assert property (!req_w |-> !WB_ACK_OUT)
      else $error("ack without a request");
   reg_read_a: assert property (WB_ACK_OUT && !WB_WE_IN &&
      WB_ADR_IN == 4'h0 |-> WB_DAT_OUT[31:6] == 26'h0 && !WB_DAT_OUT[2])
      else $error("reserved or acknowledge bit read nonzero");
   pull_dir_a: assert property (
      PULL_DOWN_SELECT_OUT |-> PULL_ENABLE_OUT)
      else $error("pull-down selected with the pin disabled");
   pull_change_a: assert property (
      $changed({PULL_ENABLE_OUT, PULL_DOWN_SELECT_OUT}) |->
      $past(req_w) || $past(req_w, 2))
      else $error("pull setting moved without a write");
   irq_source_a: assert property (
      $rose(IRQ_REQUEST_OUT) |-> PULL_ENABLE_OUT || req_w || $past(req_w))
      else $error("request rose with the pin disabled");
   irq_hold_a: assert property (
      $fell(IRQ_REQUEST_OUT) |->
      $past(req_w) || $past(req_w, 2) || $past(req_w, 3))
      else $error("request fell without a write");
   cover property ($rose(IRQ_REQUEST_OUT));
   cover property ($fell(IRQ_REQUEST_OUT));
   cover property ($rose(PULL_DOWN_SELECT_OUT));
endmodule // epid_checker
bind epid_top epid_checker u_chk (.SYS_CLK_IN(SYS_CLK_IN),
   .ARST_N_IN(ARST_N_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
   .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_DAT_OUT(WB_DAT_OUT),
   .WB_ACK_OUT(WB_ACK_OUT), .PULL_ENABLE_OUT(PULL_ENABLE_OUT),
   .PULL_DOWN_SELECT_OUT(PULL_DOWN_SELECT_OUT),
   .IRQ_REQUEST_OUT(IRQ_REQUEST_OUT));
`default_nettype wire

// File: tb/epid_src_model.sv
// Model of the external source that drives the request pin.
`timescale 1ns/10ps
`default_nettype none
module epid_src_model (
   input  wire logic clk_in,
   input  wire logic level_in,
   output var  logic pin_out
);
   // A push-pull source, so the pin is never left floating.
   initial pin_out = 1'b1;
   always @(posedge clk_in) pin_out <= level_in;
endmodule // epid_src_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the pin interrupt detector.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clk, rst_n, cyc, stb, we, lvl, pin, ack, pen, pdn, irq;
   logic [3:0]  sel, adr;
   logic [31:0] wdat, rdat, rng;
   logic [7:0]  exp_q[$];
   logic [7:0]  cfg;
   int          error_cnt = 0;
   int          total_checks = 0;
   epid_top DUT (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .WB_CYC_IN(cyc),
      .WB_STB_IN(stb), .WB_WE_IN(we), .WB_SEL_IN(sel), .WB_ADR_IN(adr),
      .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
      .EXT_PIN_IN(pin), .PULL_ENABLE_OUT(pen),
      .PULL_DOWN_SELECT_OUT(pdn), .IRQ_REQUEST_OUT(irq));
   epid_src_model u_src (.clk_in(clk), .level_in(lvl), .pin_out(pin));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string what);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Reads are noted here and compared when the ack shows up.
   task automatic wb(input logic w, input logic [3:0] a,
                     input logic [7:0] d, input logic [3:0] s,
                     input logic [7:0] e);
      int n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= {rng[31:8], d};
      if (!w) exp_q.push_back(e);
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         error_cnt++;
         results();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] d);
      wb(1'b1, 4'h0, d, 4'h1, 8'h00);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00, 4'h1, e);
   endtask
   task automatic drive(input logic v);
      @(posedge clk);
      lvl <= v;
      repeat (8) @(posedge clk);
   endtask
   always @(posedge clk)
      if (ack === 1'b1 && !we)
         check(rdat[7:0], exp_q.pop_front(), "read data");
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      {rst_n, cyc, stb, we, sel, adr, wdat} = '0;
      lvl = 1'b1;
      rng = 32'h0000_5a2a;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(4'h0, 8'h00);
      for (int p = 0; p < 2; p++)
         for (int m = 0; m < 2; m++) begin
            cfg = {2'b00, p[0], 1'b1, 2'b00, 1'b1, m[0]};
            wr(8'h04);
            drive(~p[0]);
            // Reserved and flag bits written high must not stick.
            wr(cfg | 8'hcc);
            repeat (4) @(posedge clk);
            check({6'h0, pen, pdn}, {7'h01, p[0]}, "pulls");
            rd(4'h0, cfg);
            drive(p[0]);
            check({7'h0, irq}, 8'h01, "irq set");
            rd(4'h0, cfg | 8'h08);
            wr(cfg | 8'h04);
            repeat (4) @(posedge clk);
            check({7'h0, irq}, {7'h0, m[0]}, "irq held");
            drive(~p[0]);
            wr(cfg | 8'h04);
            repeat (4) @(posedge clk);
            check({7'h0, irq}, 8'h00, "irq cleared");
            $display("test polarity %0d mode %0d done", p, m);
         end
      wr(8'h10);
      drive(1'b1);
      drive(1'b0);
      check({7'h0, irq}, 8'h00, "irq masked");
      rd(4'h0, 8'h18);
      wr(8'h04);
      drive(1'b1);
      drive(1'b0);
      check({6'h0, pen, pdn}, 8'h00, "pulls off");
      rd(4'h0, 8'h00); // Disabled pin makes no event.
      rd(4'h4, 8'h02); // Low pin counts as asserted for falling polarity.
      $display("test enable and mask done");
      repeat (4) begin
         rng = xs(rng);
         wb(1'b1, 4'h0, rng[7:0], 4'he, 8'h00);
         rd(4'h0, 8'h00);
         rd({1'b1, rng[8], 2'b00}, 8'h00);
      end
      $display("test lanes and unmapped done");
      results();
   end
endmodule // tb_top
`default_nettype wire
